// ---- design/ocp_compare.sv ----
`timescale 1ns/1ns
// Contract
// - Idle-halt bit set stops channel during idle
// - Fault status set by hardware only, cleared by any control write; code keeps it set if mode 111 runs on with the fault pin low
// - Fault status matters only in mode 111
// - Timebase choice: one third, zero second
// - Mode 000 holds the output low and raises no flag; the pulse sequencer still steps on matches
// - Mode 001 starts low, match forces high
// - Mode 010 starts high, match forces low
// - Mode 011 match toggles the output
// - Mode 100 one pulse, then stays low
// - Mode 101 pulse on every compare cycle
// - Mode 110 PWM ignores fault input
// - Mode 111 PWM watches fault input
// - One fault input shared by both channels
// - Unimplemented control bits read zero
// - Primary match rises, secondary falls, sets flag
// - Secondary copies to duty at period match
// - Duty zero low, above period high
// - Period value N gives N+1 counts
`include "ocp_regs.svh"
module ocp_compare (
    input wire logic clock, // 100 MHz system clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic [3:0] reg_addr, // Register word address
    input wire logic [15:0] reg_wdata, // Register write data
    input wire logic reg_wr, // Write strobe, one cycle
    input wire logic reg_rd, // Read strobe, one cycle
    output logic [15:0] reg_rdata, // Read data, cycle after strobe
    input wire logic cpu_idle, // CPU idle mode level
    input wire logic [15:0] second_timebase, // Count of the second timer
    input wire logic [15:0] third_timebase, // Count of the third timer
    input wire logic [15:0] second_period, // Period value of the second timer
    input wire logic [15:0] third_period, // Period value of the third timer
    input wire logic shared_fault_input_n, // Shared fault pin, active low
    output logic compare_output_pin, // Compare output level
    output logic channel_event_flag // One-cycle channel event pulse
);
    logic [15:0] compare_control;
    logic [15:0] primary_compare_value;
    logic [15:0] secondary_compare_value;
    logic fault_seen_status;
    logic mode_written;
    logic fault_sync;
    logic [15:0] timebase_count;
    logic [15:0] period_value;
    logic [15:0] last_count;
    logic count_valid;
    logic halted;
    logic advanced;
    logic pwm_mode;
    logic match_primary;
    logic match_secondary;
    logic match_period;
    logic period_start;
    ocp_pkg::ocp_mode_e channel_function_field;
    ocp_pkg::ocp_pulse_e pulse_state;
    ocp_pkg::ocp_pulse_e next_pulse_state;
    logic next_pin;
    logic next_flag;

    // Fault pin is asynchronous; resting level is high (no fault)
    ocp_sync #(
        .WIDTH(1),
        .INIT(1'b1)
    ) u_fault_sync (
        .clock(clock),
        .rst_n(rst_n),
        .async_in(shared_fault_input_n),
        .sync_out(fault_sync)
    );

    function automatic logic is_pwm(input ocp_pkg::ocp_mode_e m);
        is_pwm = (m == ocp_pkg::OCP_PWM) || (m == ocp_pkg::OCP_PWM_FAULT);
    endfunction

    assign channel_function_field =
        ocp_pkg::ocp_mode_e'(compare_control[`OCP_MODE_HI:`OCP_MODE_LO]);
    assign pwm_mode = is_pwm(channel_function_field);

    // Time base selection
    always_comb begin
        if (compare_control[`OCP_BIT_TIMEBASE]) begin
            timebase_count = third_timebase;
            period_value = third_period;
        end else begin
            timebase_count = second_timebase;
            period_value = second_period;
        end
    end

    assign halted = compare_control[`OCP_BIT_IDLE_HALT] && cpu_idle;

    // A match counts once per new count value, so a stalled timer does not repeat events
    assign advanced = !halted && (!count_valid || timebase_count != last_count);
    assign match_primary = advanced && (timebase_count == primary_compare_value);
    assign match_secondary = advanced && (timebase_count == secondary_compare_value);
    assign match_period = advanced && (timebase_count == period_value);
    // Count wraps to zero after reaching the period value: N+1 counts
    assign period_start = advanced && (timebase_count == 16'h0000);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            last_count <= 16'h0000;
            count_valid <= 1'b0;
        end else begin
            if (!halted) begin
                last_count <= timebase_count;
            end
            // A fresh mode write restarts the match history
            count_valid <= !mode_written && !halted
                && (channel_function_field != ocp_pkg::OCP_OFF);
        end
    end

    // Control register: only implemented bits are stored
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            compare_control <= `OCP_CONTROL_RESET;
            mode_written <= 1'b0;
        end else begin
            mode_written <= 1'b0;
            if (reg_wr && reg_addr == `OCP_ADDR_CONTROL) begin
                compare_control <= reg_wdata & `OCP_CONTROL_WMASK;
                mode_written <= 1'b1;
            end
        end
    end

    // Secondary value writable any time; primary is read-only in PWM modes
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            secondary_compare_value <= `OCP_COMPARE_RESET;
        end else if (reg_wr && reg_addr == `OCP_ADDR_SECONDARY) begin
            secondary_compare_value <= reg_wdata;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            primary_compare_value <= `OCP_COMPARE_RESET;
        end else if (pwm_mode && match_period) begin
            primary_compare_value <= secondary_compare_value;
        end else if (!pwm_mode && reg_wr && reg_addr == `OCP_ADDR_PRIMARY) begin
            primary_compare_value <= reg_wdata;
        end
    end

    // Fault latch: only hardware sets it; a control write clears it unless mode 111 runs on with the fault pin low
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fault_seen_status <= 1'b0;
        end else if (channel_function_field == ocp_pkg::OCP_PWM_FAULT
                && !halted && !fault_sync) begin
            fault_seen_status <= 1'b1;
        end else if (mode_written) begin
            fault_seen_status <= 1'b0;
        end
    end

    // Pulse-mode sequencing for single and continuous pulses
    always_comb begin
        next_pulse_state = pulse_state;
        case (pulse_state)
            ocp_pkg::OCP_PS_WAIT_RISE: begin
                if (match_primary) begin
                    next_pulse_state = ocp_pkg::OCP_PS_WAIT_FALL;
                end
            end
            ocp_pkg::OCP_PS_WAIT_FALL: begin
                if (match_secondary) begin
                    if (channel_function_field == ocp_pkg::OCP_PULSES) begin
                        next_pulse_state = ocp_pkg::OCP_PS_WAIT_RISE;
                    end else begin
                        next_pulse_state = ocp_pkg::OCP_PS_DONE;
                    end
                end
            end
            default: begin
                next_pulse_state = ocp_pkg::OCP_PS_DONE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pulse_state <= ocp_pkg::OCP_PS_WAIT_RISE;
        end else if (mode_written) begin
            pulse_state <= ocp_pkg::OCP_PS_WAIT_RISE;
        end else begin
            pulse_state <= next_pulse_state;
        end
    end

    // Output level and event flag by mode
    always_comb begin
        next_pin = compare_output_pin;
        next_flag = 1'b0;
        case (channel_function_field)
            ocp_pkg::OCP_OFF: begin
                next_pin = 1'b0;
            end
            ocp_pkg::OCP_SET_HIGH: begin
                if (mode_written) begin
                    next_pin = 1'b0;
                end else if (match_primary) begin
                    next_pin = 1'b1;
                    next_flag = 1'b1;
                end
            end
            ocp_pkg::OCP_SET_LOW: begin
                if (mode_written) begin
                    next_pin = 1'b1;
                end else if (match_primary) begin
                    next_pin = 1'b0;
                    next_flag = 1'b1;
                end
            end
            ocp_pkg::OCP_TOGGLE: begin
                if (match_primary) begin
                    next_pin = !compare_output_pin;
                    next_flag = 1'b1;
                end
            end
            ocp_pkg::OCP_ONE_PULSE, ocp_pkg::OCP_PULSES: begin
                if (mode_written) begin
                    next_pin = 1'b0;
                end else if (pulse_state == ocp_pkg::OCP_PS_WAIT_RISE && match_primary) begin
                    next_pin = 1'b1;
                end else if (pulse_state == ocp_pkg::OCP_PS_WAIT_FALL && match_secondary) begin
                    next_pin = 1'b0;
                    next_flag = 1'b1;
                end
            end
            default: begin
                // PWM modes; mode 110 never looks at the fault
                if (channel_function_field == ocp_pkg::OCP_PWM_FAULT
                        && (fault_seen_status || !fault_sync) && !mode_written) begin
                    next_pin = 1'b0;
                    // Idle-halted channel forces the pin but holds the flag until it runs
                    next_flag = !fault_seen_status && !halted;
                end else if (halted) begin
                    next_pin = compare_output_pin;
                end else if (primary_compare_value == 16'h0000) begin
                    next_pin = 1'b0;
                end else if (primary_compare_value > period_value) begin
                    next_pin = 1'b1;
                end else if (timebase_count == primary_compare_value) begin
                    next_pin = 1'b0;
                end else if (period_start) begin
                    next_pin = 1'b1;
                end
                if (match_period && !next_flag) begin
                    next_flag = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            compare_output_pin <= 1'b0;
            channel_event_flag <= 1'b0;
        end else begin
            compare_output_pin <= next_pin;
            channel_event_flag <= next_flag;
        end
    end

    // Read port; data stands in the cycle after the strobe only
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else if (!reg_rd) begin
            reg_rdata <= 16'h0000;
        end else if (reg_addr == `OCP_ADDR_CONTROL) begin
            reg_rdata <= {compare_control[15:5], fault_seen_status, compare_control[3:0]};
        end else if (reg_addr == `OCP_ADDR_PRIMARY) begin
            reg_rdata <= primary_compare_value;
        end else if (reg_addr == `OCP_ADDR_SECONDARY) begin
            reg_rdata <= secondary_compare_value;
        end else if (reg_addr == `OCP_ADDR_STATUS) begin
            reg_rdata <= {13'h0000, pulse_state == ocp_pkg::OCP_PS_DONE, halted,
                compare_output_pin};
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    a_unimpl_bits_zero: assert property (@(posedge clock) disable iff (!rst_n)
        $past(reg_rd) && $past(reg_addr) == `OCP_ADDR_CONTROL
        |-> reg_rdata[15:14] == 2'h0 && reg_rdata[12:5] == 8'h00)
        else $error("reserved control bits read nonzero");

    a_off_pin_low: assert property (@(posedge clock) disable iff (!rst_n)
        channel_function_field == ocp_pkg::OCP_OFF && !mode_written
        |=> !compare_output_pin)
        else $error("disabled channel drove output");

    a_fault_sticky: assert property (@(posedge clock) disable iff (!rst_n)
        fault_seen_status && !mode_written |=> fault_seen_status)
        else $error("fault status cleared without mode write");

    a_fault_only_111: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(fault_seen_status)
        |-> $past(channel_function_field) == ocp_pkg::OCP_PWM_FAULT)
        else $error("fault status set outside mode 111");

    a_fault_forces_low: assert property (@(posedge clock) disable iff (!rst_n)
        fault_seen_status && channel_function_field == ocp_pkg::OCP_PWM_FAULT
        && !mode_written |=> !compare_output_pin)
        else $error("fault did not hold output low");

    a_fault_flag_once: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(fault_seen_status) && !$past(mode_written) |-> channel_event_flag)
        else $error("fault did not raise the event flag");

    a_init_high: assert property (@(posedge clock) disable iff (!rst_n)
        mode_written && channel_function_field == ocp_pkg::OCP_SET_LOW
        |=> compare_output_pin)
        else $error("mode 010 did not start high");

    a_toggle_match: assert property (@(posedge clock) disable iff (!rst_n)
        channel_function_field == ocp_pkg::OCP_TOGGLE && match_primary
        |=> compare_output_pin != $past(compare_output_pin))
        else $error("toggle mode did not invert output");

    a_pulse_fall_flag: assert property (@(posedge clock) disable iff (!rst_n)
        channel_function_field == ocp_pkg::OCP_ONE_PULSE && !mode_written
        && pulse_state == ocp_pkg::OCP_PS_WAIT_FALL && match_secondary
        |=> !compare_output_pin && channel_event_flag ##1 !channel_event_flag)
        else $error("pulse fall or flag wrong");

    a_single_stays_low: assert property (@(posedge clock) disable iff (!rst_n)
        channel_function_field == ocp_pkg::OCP_ONE_PULSE
        && pulse_state == ocp_pkg::OCP_PS_DONE
        && !mode_written |=> !compare_output_pin)
        else $error("single pulse repeated");

    a_duty_latch: assert property (@(posedge clock) disable iff (!rst_n)
        pwm_mode && match_period
        |=> primary_compare_value == $past(secondary_compare_value))
        else $error("duty not latched at period match");

    a_zero_duty_low: assert property (@(posedge clock) disable iff (!rst_n)
        pwm_mode && !halted && primary_compare_value == 16'h0000
        |=> !compare_output_pin)
        else $error("zero duty drove output high");

    a_idle_halt: assert property (@(posedge clock) disable iff (!rst_n)
        halted && channel_function_field == ocp_pkg::OCP_PWM
        |=> $stable(compare_output_pin))
        else $error("channel ran while halted in idle");
endmodule // ocp_compare

// ---- design/ocp_regs.svh ----
`ifndef OCP_REGS_SVH
`define OCP_REGS_SVH

// Register offsets on the plain register port (word addresses)
`define OCP_ADDR_CONTROL 4'h0
`define OCP_ADDR_PRIMARY 4'h1
`define OCP_ADDR_SECONDARY 4'h2
`define OCP_ADDR_STATUS 4'h3

// Control register field positions
`define OCP_BIT_IDLE_HALT 13
`define OCP_BIT_FAULT 4
`define OCP_BIT_TIMEBASE 3
`define OCP_MODE_HI 2
`define OCP_MODE_LO 0

// Writable bits of the control register
`define OCP_CONTROL_WMASK 16'h200F
`define OCP_CONTROL_RESET 16'h0000
`define OCP_COMPARE_RESET 16'h0000

`endif

// ---- design/ocp_pkg.sv ----
package ocp_pkg;

    typedef enum logic [2:0] {
        OCP_OFF = 3'h0,
        OCP_SET_HIGH = 3'h1,
        OCP_SET_LOW = 3'h2,
        OCP_TOGGLE = 3'h3,
        OCP_ONE_PULSE = 3'h4,
        OCP_PULSES = 3'h5,
        OCP_PWM = 3'h6,
        OCP_PWM_FAULT = 3'h7
    } ocp_mode_e;

    typedef enum logic [1:0] {
        OCP_PS_WAIT_RISE = 2'h0,
        OCP_PS_WAIT_FALL = 2'h1,
        OCP_PS_DONE = 2'h2
    } ocp_pulse_e;

endpackage

// ---- design/ocp_sync.sv ----
`timescale 1ns/1ns
// Two-stage synchroniser for the pin-level inputs
module ocp_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clock, // System clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic [WIDTH-1:0] async_in, // Level from another domain
    output logic [WIDTH-1:0] sync_out // Level in the clock domain
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= INIT;
            sync_out <= INIT;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule // ocp_sync

// ---- verification/ocp_timer_model.sv ----
`timescale 1ns/1ns
// Far side of the channel: two free-running time bases and the fault pin
module ocp_timer_model (
    input wire logic clock, // System clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic [15:0] second_period, // Wrap value of the second time base
    input wire logic [15:0] third_period, // Wrap value of the third time base
    input wire logic fault_req, // Bench asks for a fault
    output logic [15:0] second_timebase, // Second time base count
    output logic [15:0] third_timebase, // Third time base count
    output logic shared_fault_input_n // Fault pin, active low
);
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            second_timebase <= 16'h0000;
        end else if (second_timebase >= second_period) begin
            second_timebase <= 16'h0000;
        end else begin
            second_timebase <= second_timebase + 16'h0001;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            third_timebase <= 16'h0000;
        end else if (third_timebase >= third_period) begin
            third_timebase <= 16'h0000;
        end else begin
            third_timebase <= third_timebase + 16'h0001;
        end
    end

    // Pulled high when nobody signals a fault; one pin feeds both channels
    assign shared_fault_input_n = !fault_req;
endmodule // ocp_timer_model

// ---- verification/tb_ocp_compare.sv ----
`timescale 1ns/1ns
`include "ocp_regs.svh"
module tb_ocp_compare;
    typedef struct {
        logic [15:0] ctrl;
        logic [15:0] pri;
        logic [15:0] sec;
        logic idle;
        logic pin;
        int rises;
        int flags;
    } ocp_row_s;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic cpu_idle = 1'b0;
    logic [15:0] second_timebase;
    logic [15:0] third_timebase;
    logic [15:0] second_period = 16'h000F;
    logic [15:0] third_period = 16'h001F;
    logic fault_req = 1'b0;
    logic shared_fault_input_n;
    logic compare_output_pin;
    logic channel_event_flag;
    logic last_pin = 1'b0;
    logic [15:0] seen;
    int rises = 0;
    int flags = 0;
    int r0;
    int f0;
    int err_count = 0;
    int checks_done = 0;
    // Windows start near count 9, away from every edge of interest
    ocp_row_s rows [17] = '{
        '{16'h0000, 16'h0005, 16'h0006, 1'b0, 1'b0, 0, 0},
        '{16'h0001, 16'h0005, 16'h0006, 1'b0, 1'b1, 1, 4},
        '{16'h0003, 16'h0005, 16'h0006, 1'b0, 1'bx, 2, 4},
        '{16'h0002, 16'h0005, 16'h0006, 1'b0, 1'b0, -1, 4},
        '{16'h0004, 16'h0003, 16'h0006, 1'b0, 1'b0, 1, 1},
        '{16'h0005, 16'h0003, 16'h0006, 1'b0, 1'b0, 4, 4},
        '{16'h200D, 16'h0003, 16'h0006, 1'b1, 1'b0, 0, 0},
        '{16'h0005, 16'h0003, 16'h0006, 1'b1, 1'b0, 4, 4},
        '{16'hFFF5, 16'h0003, 16'h0006, 1'b0, 1'b0, 4, 4},
        '{16'h0009, 16'h0014, 16'h0016, 1'b0, 1'b1, 1, 2},
        '{16'h0001, 16'h0014, 16'h0016, 1'b0, 1'b0, 0, 0},
        '{16'h0006, 16'h0006, 16'h0006, 1'b0, 1'b0, 4, -1},
        '{16'h0006, 16'h0000, 16'h0000, 1'b0, 1'b0, 0, -1},
        '{16'h0007, 16'h0006, 16'h0006, 1'b0, 1'b0, 4, -1},
        '{16'h0006, 16'h000F, 16'h000F, 1'b0, 1'b1, 4, -1},
        '{16'h0006, 16'h0010, 16'h0010, 1'b0, 1'b1, -1, -1},
        '{16'h2006, 16'h0006, 16'h0006, 1'b1, 1'b0, 0, 0}
    };

    always #5 clock = ~clock;

    ocp_timer_model model_u (.clock(clock), .rst_n(rst_n), .second_period(second_period),
        .third_period(third_period), .fault_req(fault_req), .second_timebase(second_timebase),
        .third_timebase(third_timebase), .shared_fault_input_n(shared_fault_input_n));

    ocp_compare dut_u (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cpu_idle(cpu_idle), .second_timebase(second_timebase),
        .third_timebase(third_timebase), .second_period(second_period),
        .third_period(third_period), .shared_fault_input_n(shared_fault_input_n),
        .compare_output_pin(compare_output_pin), .channel_event_flag(channel_event_flag));

    always @(posedge clock) begin
        last_pin <= compare_output_pin;
        if (compare_output_pin === 1'b1 && last_pin === 1'b0) rises <= rises + 1;
        if (channel_event_flag === 1'b1) flags <= flags + 1;
    end

    task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic sync_to(input logic third, input logic [15:0] v);
        for (int i = 0; i < 100; i++) begin
            @(posedge clock);
            #1;
            if ((third ? third_timebase : second_timebase) === v) break;
        end
    endtask

    // Primary is written with the channel off, since PWM modes refuse it
    task automatic setup(input ocp_row_s r);
        sync_to(r.ctrl[3], 16'h0002);
        reg_write(`OCP_ADDR_CONTROL, 16'h0000);
        reg_write(`OCP_ADDR_PRIMARY, r.pri);
        reg_write(`OCP_ADDR_SECONDARY, r.sec);
        cpu_idle <= r.idle;
        reg_write(`OCP_ADDR_CONTROL, r.ctrl);
    endtask

    task automatic print_verdict();
        $display("errors %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            setup(rows[i]);
            r0 = rises;
            f0 = flags;
            repeat (64) @(posedge clock);
            #1;
            if (rows[i].pin !== 1'bx) check("pin", 16'(compare_output_pin), 16'(rows[i].pin));
            if (rows[i].rises >= 0) check("rises", 16'(rises - r0), 16'(rows[i].rises));
            if (rows[i].flags >= 0) check("flags", 16'(flags - f0), 16'(rows[i].flags));
            reg_read(`OCP_ADDR_CONTROL, seen);
            check("control", seen, rows[i].ctrl & 16'h200F);
        end
        setup('{16'h0006, 16'h0006, 16'h0006, 1'b0, 1'b0, 0, 0});
        sync_to(1'b0, 16'h0000);
        reg_write(`OCP_ADDR_SECONDARY, 16'h0004);
        sync_to(1'b0, 16'h0006);
        check("old duty", 16'(compare_output_pin), 16'h0001);
        sync_to(1'b0, 16'h0005);
        check("new duty", 16'(compare_output_pin), 16'h0000);
        reg_write(`OCP_ADDR_PRIMARY, 16'h0009);
        reg_read(`OCP_ADDR_PRIMARY, seen);
        check("duty read only", seen, 16'h0004);
        setup('{16'h0007, 16'h0010, 16'h0010, 1'b0, 1'b0, 0, 0});
        f0 = flags;
        fault_req <= 1'b1;
        repeat (6) @(posedge clock);
        #1;
        check("fault pin", 16'(compare_output_pin), 16'h0000);
        check("fault flag", 16'(flags - f0), 16'h0001);
        fault_req <= 1'b0;
        repeat (40) @(posedge clock);
        #1;
        check("fault hold", 16'(compare_output_pin), 16'h0000);
        reg_read(`OCP_ADDR_CONTROL, seen);
        check("fault bit", seen, 16'h0017);
        reg_write(`OCP_ADDR_CONTROL, 16'h0016);
        reg_read(`OCP_ADDR_CONTROL, seen);
        check("no sw set", seen, 16'h0006);
        fault_req <= 1'b1;
        repeat (40) @(posedge clock);
        #1;
        check("fault ignored", 16'(compare_output_pin), 16'h0001);
        reg_read(`OCP_ADDR_CONTROL, seen);
        check("fault unused", seen, 16'h0006);
        fault_req <= 1'b0;
        reg_write(4'h9, 16'hFFFF);
        reg_read(4'h9, seen);
        check("unmapped", seen, 16'h0000);
        reg_read(`OCP_ADDR_CONTROL, seen);
        check("control kept", seen, 16'h0006);
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (3) @(posedge clock);
        #1;
        check("reset pin", 16'(compare_output_pin), 16'h0000);
        @(posedge clock);
        rst_n <= 1'b1;
        reg_read(`OCP_ADDR_CONTROL, seen);
        check("reset control", seen, 16'h0000);
        print_verdict();
    end

    // About 17 setups of under 200 cycles each plus the hand tests
    initial begin
        repeat (20000) @(posedge clock);
        err_count++;
        print_verdict();
    end
endmodule // tb_ocp_compare
